// ==== design/ccm_pkg.sv ====
package ccm_pkg;

  localparam int         ADDR_W     = 5;
  localparam int         DATA_W     = 8;
  localparam int         NTHR       = 8;

  localparam logic [4:0] A_THR0     = 5'h00;
  localparam logic [4:0] A_CTRL     = 5'h08;
  localparam logic [4:0] A_DEB      = 5'h09;
  localparam logic [4:0] A_DBCLR1   = 5'h0a;
  localparam logic [4:0] A_DBCLR2   = 5'h0b;
  localparam logic [4:0] A_MEN1     = 5'h0c;
  localparam logic [4:0] A_MEN2     = 5'h0d;
  localparam logic [4:0] A_MATCH1   = 5'h0e;
  localparam logic [4:0] A_MATCH2   = 5'h0f;
  localparam logic [4:0] A_CHG1     = 5'h10;
  localparam logic [4:0] A_CHG2     = 5'h11;
  localparam logic [4:0] A_STAT     = 5'h12;
  localparam logic [4:0] A_MON      = 5'h13;

  localparam int         CTRL_DBEN  = 0;
  localparam int         CTRL_SNK   = 1;
  localparam int         CTRL_ADV   = 2;
  localparam int         CTRL_SAMP  = 4;
  localparam int         ST_VLD     = 0;
  localparam int         ST_DBG     = 1;
  localparam int         ST_AUD     = 2;
  localparam int         ST_VBUS    = 3;
  localparam int         ST_VCONN   = 4;
  localparam int         ST_LVL     = 5;
  localparam int         ST_SNK     = 7;
  localparam int         MON_ATT    = 0;
  localparam int         MON_DET    = 2;

  localparam int         OPEN_DEF   = 5;
  localparam int         OPEN_HIGH  = 6;
  localparam int         OPEN_VND   = 7;
  localparam int         SK_DEF     = 0;
  localparam int         SK_MID     = 2;
  localparam int         SK_HIGH    = 4;
  localparam int         SK_VND     = 7;

  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [7:0]  RST_DEB   = 8'h01;
  localparam logic [7:0]  RST_MASK  = 8'h00;
  localparam logic [63:0] RST_THR   = 64'h9682503e2821140a;

  localparam int         CLK_NS     = 10;
  localparam int         TICK_NS    = 1000;
  localparam logic [6:0] TICK_CYC   = 7'((TICK_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {ADV_DEF = 2'h0, ADV_MID = 2'h1, ADV_HIGH = 2'h2, ADV_VND = 2'h3} adv_t;
  typedef enum logic [2:0] {DB_OFF = 3'h1, DB_WAIT = 3'h2, DB_RUN = 3'h4} db_state_t;

endpackage

// ==== design/ccm_debounce.sv ====
`timescale 1ns/10ps
`default_nettype none
module ccm_debounce (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [7:0] raw,
  input  wire logic [7:0] en,
  input  wire logic [7:0] dbclr,
  input  wire logic [7:0] interval,
  output logic      [7:0] match,
  output logic      [7:0] chg,
  output logic            valid
);

  typedef struct packed {
    ccm_pkg::db_state_t st;
    logic [7:0]         cand;
    logic [7:0]         match;
    logic [7:0]         chg;
    logic [7:0]         cnt;
    logic [6:0]         pre;
    logic               valid;
  } db_t;

  db_t        state_r;
  db_t        state_nxt;
  logic [7:0] masked;
  logic       tick;
  logic       due;
  logic       restart;

  assign masked  = raw & en;
  assign tick    = state_r.pre == 7'(ccm_pkg::TICK_CYC - 7'h01);
  assign due     = tick && (8'(state_r.cnt + 8'h01) >= interval);
  assign restart = ((masked ^ state_r.cand) & dbclr) != 8'h00;

  always_comb
  begin
    state_nxt     = state_r;
    state_nxt.chg = 8'h00;
    unique case (state_r.st)
      ccm_pkg::DB_OFF:
      begin
        if (run)
        begin
          state_nxt.st   = ccm_pkg::DB_WAIT;
          state_nxt.cand = masked;
          state_nxt.cnt  = 8'h00;
          state_nxt.pre  = 7'h00;
        end
      end
      ccm_pkg::DB_WAIT, ccm_pkg::DB_RUN:
      begin
        state_nxt.cand = masked;
        if (!run)
        begin
          state_nxt.st    = ccm_pkg::DB_OFF;
          state_nxt.match = 8'h00;
          state_nxt.valid = 1'b0;
        end
        else if (restart)
        begin
          state_nxt.cnt = 8'h00;
          state_nxt.pre = 7'h00;
        end
        else
        begin
          state_nxt.pre = tick ? 7'h00 : 7'(state_r.pre + 7'h01);
          state_nxt.cnt = due ? 8'h00 : (tick ? 8'(state_r.cnt + 8'h01) : state_r.cnt);
          if (due)
          begin
            state_nxt.chg   = masked ^ state_r.match;
            state_nxt.match = masked;
            state_nxt.valid = 1'b1;
            state_nxt.st    = ccm_pkg::DB_RUN;
          end
        end
      end
      default: state_nxt.st = ccm_pkg::DB_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= '{st: ccm_pkg::DB_OFF, default: '0};
    else
      state_r <= state_nxt;
  end

  assign match = state_r.match;
  assign chg   = state_r.chg;
  assign valid = state_r.valid;

  AST_DEB_LOAD: assert property (@(posedge clk) disable iff (srst)
    (state_r.st != ccm_pkg::DB_OFF && state_r.match != $past(state_r.match)) |-> $past(due))
    else $error("Match changed before the debounce interval ran out.");
  AST_DEB_RESTART: assert property (@(posedge clk) disable iff (srst)
    (run && state_r.st != ccm_pkg::DB_OFF && restart) |=> state_r.match == $past(state_r.match))
    else $error("Match loaded while input was still moving.");

endmodule // ccm_debounce
`default_nettype wire

// ==== design/ccm_classify.sv ====
`timescale 1ns/10ps
`default_nettype none
module ccm_classify (
  input  wire logic         snk,
  input  wire ccm_pkg::adv_t adv,
  input  wire logic [7:0]   m1,
  input  wire logic [7:0]   m2,
  output logic              vbus,
  output logic              vconn,
  output logic [1:0]        att,
  output logic [1:0]        det,
  output logic              dbg,
  output logic              aud,
  output logic              sattached,
  output logic [1:0]        slvl
);

  always_comb
  begin
    int         oi;
    logic [1:0] o;
    logic [1:0] c;
    logic [1:0] d;
    logic [7:0] u;
    oi = ccm_pkg::OPEN_DEF;
    unique case (adv)
      ccm_pkg::ADV_DEF:  oi = ccm_pkg::OPEN_DEF;
      ccm_pkg::ADV_MID:  oi = ccm_pkg::OPEN_DEF;
      ccm_pkg::ADV_HIGH: oi = ccm_pkg::OPEN_HIGH;
      ccm_pkg::ADV_VND:  oi = ccm_pkg::OPEN_VND;
    endcase
    o         = {m2[oi], m1[oi]};
    c         = {m2 == 8'h00, m1 == 8'h00};
    d         = ~o & ~c;
    u         = m1 | m2;
    vbus      = 1'b0;
    vconn     = 1'b0;
    att       = 2'b00;
    det       = 2'b00;
    dbg       = 1'b0;
    aud       = 1'b0;
    sattached = 1'b0;
    slvl      = ccm_pkg::ADV_DEF;
    if (snk)
    begin
      sattached = u[ccm_pkg::SK_DEF];
      det       = {m2[ccm_pkg::SK_DEF], m1[ccm_pkg::SK_DEF]};
      if (u[ccm_pkg::SK_VND])
        slvl = ccm_pkg::ADV_VND;
      else if (u[ccm_pkg::SK_HIGH])
        slvl = ccm_pkg::ADV_HIGH;
      else if (u[ccm_pkg::SK_MID])
        slvl = ccm_pkg::ADV_MID;
    end
    else if (o == 2'b11)
      att = 2'b11;
    else if (d == 2'b11)
    begin
      dbg = 1'b1;
      det = 2'b11;
    end
    else if (c == 2'b11)
    begin
      aud = 1'b1;
      det = 2'b11;
    end
    else if (d != 2'b00 && c != 2'b00)
    begin
      det   = d;
      vbus  = 1'b1;
      vconn = 1'b1;
    end
    else if (d != 2'b00)
    begin
      det  = d;
      vbus = 1'b1;
    end
    else
    begin
      att = o;
      det = c;
    end
  end

endmodule // ccm_classify
`default_nettype wire

// ==== design/cc_threshold_match_classifier.sv ====
`timescale 1ns/10ps
`default_nettype none
module cc_threshold_match_classifier (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [7:0]  cmp_cc1,
  input  wire logic [7:0]  cmp_cc2,
  output logic      [63:0] thr_level,
  output logic      [1:0]  sample_en,
  output logic             vbus_en,
  output logic             vconn_en,
  output logic             match_valid_flag,
  output logic             dbg_acc,
  output logic             aud_acc,
  output logic      [1:0]  mon_attach,
  output logic      [1:0]  mon_detach
);

  typedef struct packed {
    logic [63:0]     thr;
    logic [7:0]      ctrl;
    logic [7:0]      deb;
    logic [1:0][7:0] dbclr;
    logic [1:0][7:0] men;
    logic [1:0][7:0] chg;
    logic [7:0]      rdata;
    logic            vbus;
    logic            vconn;
    logic            vld;
    logic            dbg;
    logic            aud;
    logic [1:0]      att;
    logic [1:0]      det;
    logic [1:0]      slvl;
    logic            sattached;
  } top_t;

  top_t            state_r;
  top_t            state_nxt;
  logic [1:0][7:0] raw;
  logic [1:0][7:0] dm;
  logic [1:0][7:0] dchg;
  logic [1:0][7:0] mm;
  logic [1:0]      dv;
  logic [1:0]      run;
  logic            snk;
  ccm_pkg::adv_t   adv;
  logic            cl_vbus;
  logic            cl_vconn;
  logic [1:0]      cl_att;
  logic [1:0]      cl_det;
  logic            cl_dbg;
  logic            cl_aud;
  logic            cl_satt;
  logic [1:0]      cl_slvl;

  assign raw = {cmp_cc2, cmp_cc1};
  assign snk = state_r.ctrl[ccm_pkg::CTRL_SNK];
  assign adv = ccm_pkg::adv_t'(state_r.ctrl[ccm_pkg::CTRL_ADV +: 2]);

  generate
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
      assign run[p] = state_r.ctrl[ccm_pkg::CTRL_DBEN] && state_r.ctrl[ccm_pkg::CTRL_SAMP + p];
      assign mm[p]  = dm[p] & state_r.men[p];
      ccm_debounce u_deb (
        .clk      (clk),
        .srst     (srst),
        .run      (run[p]),
        .raw      (raw[p]),
        .en       (state_r.men[p]),
        .dbclr    (state_r.dbclr[p]),
        .interval (state_r.deb),
        .match    (dm[p]),
        .chg      (dchg[p]),
        .valid    (dv[p])
      );
    end
  endgenerate

  ccm_classify u_cls (
    .snk       (snk),
    .adv       (adv),
    .m1        (mm[0]),
    .m2        (mm[1]),
    .vbus      (cl_vbus),
    .vconn     (cl_vconn),
    .att       (cl_att),
    .det       (cl_det),
    .dbg       (cl_dbg),
    .aud       (cl_aud),
    .sattached (cl_satt),
    .slvl      (cl_slvl)
  );

  always_comb
  begin
    logic [1:0][7:0] clr;
    clr             = '0;
    state_nxt       = state_r;
    state_nxt.rdata = 8'h00;
    if (wr)
    begin
      if (addr < ccm_pkg::A_CTRL)
        state_nxt.thr[{addr[2:0], 3'h0} +: 8] = wdata;
      else
      begin
        case (addr)
          ccm_pkg::A_CTRL:   state_nxt.ctrl     = wdata;
          ccm_pkg::A_DEB:    state_nxt.deb      = wdata;
          ccm_pkg::A_DBCLR1: state_nxt.dbclr[0] = wdata;
          ccm_pkg::A_DBCLR2: state_nxt.dbclr[1] = wdata;
          ccm_pkg::A_MEN1:   state_nxt.men[0]   = wdata;
          ccm_pkg::A_MEN2:   state_nxt.men[1]   = wdata;
          ccm_pkg::A_CHG1:   clr[0]             = wdata;
          ccm_pkg::A_CHG2:   clr[1]             = wdata;
          default:           clr                = '0;
        endcase
      end
    end
    for (int p = 0; p < 2; p++)
      state_nxt.chg[p] = ((state_r.chg[p] & ~clr[p]) | dchg[p]) & state_r.men[p];
    if (rd)
    begin
      if (addr < ccm_pkg::A_CTRL)
        state_nxt.rdata = state_r.thr[{addr[2:0], 3'h0} +: 8];
      else
      begin
        case (addr)
          ccm_pkg::A_CTRL:   state_nxt.rdata = state_r.ctrl;
          ccm_pkg::A_DEB:    state_nxt.rdata = state_r.deb;
          ccm_pkg::A_DBCLR1: state_nxt.rdata = state_r.dbclr[0];
          ccm_pkg::A_DBCLR2: state_nxt.rdata = state_r.dbclr[1];
          ccm_pkg::A_MEN1:   state_nxt.rdata = state_r.men[0];
          ccm_pkg::A_MEN2:   state_nxt.rdata = state_r.men[1];
          ccm_pkg::A_MATCH1: state_nxt.rdata = mm[0];
          ccm_pkg::A_MATCH2: state_nxt.rdata = mm[1];
          ccm_pkg::A_CHG1:   state_nxt.rdata = state_r.chg[0];
          ccm_pkg::A_CHG2:   state_nxt.rdata = state_r.chg[1];
          ccm_pkg::A_STAT:
          begin
            state_nxt.rdata[ccm_pkg::ST_VLD]        = state_r.vld;
            state_nxt.rdata[ccm_pkg::ST_DBG]        = state_r.dbg;
            state_nxt.rdata[ccm_pkg::ST_AUD]        = state_r.aud;
            state_nxt.rdata[ccm_pkg::ST_VBUS]       = state_r.vbus;
            state_nxt.rdata[ccm_pkg::ST_VCONN]      = state_r.vconn;
            state_nxt.rdata[ccm_pkg::ST_LVL +: 2]   = state_r.slvl;
            state_nxt.rdata[ccm_pkg::ST_SNK]        = state_r.sattached;
          end
          ccm_pkg::A_MON:
          begin
            state_nxt.rdata[ccm_pkg::MON_ATT +: 2] = state_r.att;
            state_nxt.rdata[ccm_pkg::MON_DET +: 2] = state_r.det;
          end
          default: state_nxt.rdata = 8'h00;
        endcase
      end
    end
    state_nxt.vld       = dv[0] && dv[1];
    state_nxt.vbus      = state_nxt.vld && cl_vbus;
    state_nxt.vconn     = state_nxt.vld && cl_vconn;
    state_nxt.att       = state_nxt.vld ? cl_att : 2'b00;
    state_nxt.det       = state_nxt.vld ? cl_det : 2'b00;
    state_nxt.dbg       = state_nxt.vld && cl_dbg;
    state_nxt.aud       = state_nxt.vld && cl_aud;
    state_nxt.sattached = state_nxt.vld && cl_satt;
    state_nxt.slvl      = state_nxt.vld ? cl_slvl : 2'b00;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r       <= '0;
      state_r.thr   <= ccm_pkg::RST_THR;
      state_r.ctrl  <= ccm_pkg::RST_CTRL;
      state_r.deb   <= ccm_pkg::RST_DEB;
      state_r.dbclr <= {ccm_pkg::RST_MASK, ccm_pkg::RST_MASK};
      state_r.men   <= {ccm_pkg::RST_MASK, ccm_pkg::RST_MASK};
    end
    else
      state_r <= state_nxt;
  end

  assign rdata            = state_r.rdata;
  assign thr_level        = state_r.thr;
  assign sample_en        = state_r.ctrl[ccm_pkg::CTRL_SAMP +: 2];
  assign vbus_en          = state_r.vbus;
  assign vconn_en         = state_r.vconn;
  assign match_valid_flag = state_r.vld;
  assign dbg_acc          = state_r.dbg;
  assign aud_acc          = state_r.aud;
  assign mon_attach       = state_r.att;
  assign mon_detach       = state_r.det;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_MATCH_MASK: assert property (
    (rd && addr == ccm_pkg::A_MATCH1) |=> (rdata & ~$past(state_r.men[0])) == 8'h00)
    else $error("Disabled threshold read as set.");

  AST_CHG_SET: assert property (
    (dchg[0] & state_r.men[0]) != 8'h00
    |=> (state_r.chg[0] & $past(dchg[0] & state_r.men[0])) == $past(dchg[0] & state_r.men[0]))
    else $error("Change status missed a debounced change.");

  AST_CHG_HOLD: assert property (
    !(wr && addr == ccm_pkg::A_CHG1) && $past(state_r.men[0]) == state_r.men[0]
    |=> (state_r.chg[0] & $past(state_r.chg[0])) == $past(state_r.chg[0]))
    else $error("Change status dropped without a clear.");

  AST_VALID_UP: assert property (
    (dv == 2'b11) |=> match_valid_flag)
    else $error("Valid flag late after both pins settled.");

  AST_VALID_DOWN: assert property (
    (dv != 2'b11) |=> !match_valid_flag)
    else $error("Valid flag set before both pins settled.");

  AST_UNATT: assert property (
    (!snk && cl_att == 2'b11) |-> !cl_vbus && !cl_vconn && cl_det == 2'b00)
    else $error("Unattached port powered or watched for detach.");

  AST_ONE_DET: assert property (
    (!snk && cl_vbus) |-> $onehot(cl_det))
    else $error("Powered port watches other than one pin.");

  AST_VCONN: assert property (
    cl_vconn |-> cl_vbus && $onehot(cl_det) && cl_att == 2'b00)
    else $error("VCONN supplied outside cable plus sink.");

  AST_DEBUG: assert property (
    cl_dbg |-> !cl_vbus && !cl_vconn && cl_det == 2'b11)
    else $error("Debug accessory handled wrongly.");

  AST_AUDIO: assert property (
    cl_aud |-> !cl_vconn && cl_det == 2'b11)
    else $error("Audio accessory handled wrongly.");

  AST_OUT_LAG: assert property (
    (cl_dbg && dv == 2'b11) |=> dbg_acc && !vbus_en)
    else $error("Debug accessory output not registered.");

  AST_MATCH2_MASK: assert property (
    (rd && addr == ccm_pkg::A_MATCH2) |=> (rdata & ~$past(state_r.men[1])) == 8'h00)
    else $error("Disabled threshold read as set on the second pin.");

  AST_CHG2_SET: assert property (
    (dchg[1] & state_r.men[1]) != 8'h00
    |=> (state_r.chg[1] & $past(dchg[1] & state_r.men[1])) == $past(dchg[1] & state_r.men[1]))
    else $error("Second pin change status missed a debounced change.");

  AST_CHG_CLEAR: assert property (
    (wr && addr == ccm_pkg::A_CHG1) |=> (state_r.chg[0] & $past(wdata & ~dchg[0])) == 8'h00)
    else $error("Change status bit survived a clear.");

  AST_SNK_POWER: assert property (
    snk |-> !cl_vbus && !cl_vconn && !cl_dbg && !cl_aud && cl_att == 2'b00)
    else $error("Sink role drives source power or attach watch.");

  AST_ATT_POWER: assert property (
    (cl_att != 2'b00) |-> !cl_vbus && !cl_vconn)
    else $error("Port watched for attach while powered.");

  AST_VBUS_DET: assert property (
    cl_vbus |-> cl_att == 2'b00 && cl_det != 2'b00)
    else $error("Powered port watches for attach.");

  AST_CABLE_IGNORED: assert property (
    cl_vconn |-> (cl_det & {mm[1] == 8'h00, mm[0] == 8'h00}) == 2'b00)
    else $error("Cable pin watched for detach while VCONN is on.");

  AST_ACC_POWER: assert property (
    (cl_dbg || cl_aud) |-> !cl_vbus && !(cl_dbg && cl_aud) && cl_att == 2'b00)
    else $error("Accessory powered or reported twice.");

  AST_QUIET_INVALID: assert property (
    !match_valid_flag |-> !vbus_en && !vconn_en && !dbg_acc && !aud_acc && {mon_attach, mon_detach} == 4'h0)
    else $error("Role output active before match valid.");

  AST_VND_OPEN: assert property (
    (!snk && adv == ccm_pkg::ADV_VND && mm == {8'h80, 8'h80}) |-> cl_att == 2'b11 && !cl_vbus)
    else $error("Vendor level open pins not seen as unattached.");

  AST_HIGH_OPEN: assert property (
    (!snk && adv == ccm_pkg::ADV_HIGH && mm == {8'h48, 8'h00}) |-> cl_att == 2'b10 && cl_det == 2'b01 && !cl_vbus)
    else $error("High level open pin not watched for attach.");

  AST_DEF_SINK: assert property (
    (!snk && adv == ccm_pkg::ADV_DEF && mm == {8'h01, 8'h01}) |-> cl_dbg && cl_det == 2'b11)
    else $error("Default level sink pair not seen as debug accessory.");

  AST_MID_SINK: assert property (
    (!snk && adv == ccm_pkg::ADV_MID && mm == {8'h22, 8'h02}) |-> cl_vbus && !cl_vconn && cl_det == 2'b01)
    else $error("Mid level sink on first pin not powered.");

  AST_SNK_HIGH: assert property (
    (snk && mm == {8'h00, 8'h15}) |-> cl_slvl == ccm_pkg::ADV_HIGH && cl_satt)
    else $error("Sink missed high level source.");

  AST_SNK_MID: assert property (
    (snk && mm == {8'h05, 8'h00}) |-> cl_slvl == ccm_pkg::ADV_MID && cl_det == 2'b10)
    else $error("Sink missed mid level source on second pin.");

  AST_SNK_VND: assert property (
    (snk && mm == {8'h00, 8'h95}) |-> cl_slvl == ccm_pkg::ADV_VND && cl_satt)
    else $error("Sink missed vendor level source.");

  AST_SNK_IDLE: assert property (
    (snk && mm == 16'h0000) |-> !cl_satt && cl_det == 2'b00)
    else $error("Sink reported attach with all thresholds clear.");

  COV_VALID: cover property (match_valid_flag ##1 state_r.chg[0] != 8'h00);
  COV_DEBUG: cover property (dbg_acc);
  COV_VCONN: cover property (vconn_en);
  COV_SINK:  cover property (snk && state_r.sattached);
  COV_AUDIO: cover property (aud_acc);

endmodule // cc_threshold_match_classifier
`default_nettype wire

// ==== test/cc_partner_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cc_partner_model (
  input  wire logic          snk,
  input  wire ccm_pkg::adv_t adv,
  input  wire logic [1:0]    term1,
  input  wire logic [1:0]    term2,
  output logic      [7:0]    cmp_cc1,
  output logic      [7:0]    cmp_cc2
);
  // Termination codes: 0 open, 1 sink pull-down, 2 cable pull-down, 3 source pull-up.
  // The pin voltage is expressed as the number of ascending thresholds it crosses.
  // Role and level are arguments so that the pins follow every change of them.
  function automatic logic [7:0] crossed(input logic [1:0] t, input logic s, input ccm_pkg::adv_t a);
    int lvl;
    lvl = 0;
    case (t)
      2'h0:    lvl = s ? 0 : ((a == ccm_pkg::ADV_VND) ? 8 : 7);
      2'h2:    lvl = (a == ccm_pkg::ADV_HIGH || a == ccm_pkg::ADV_VND) ? 1 : 0;
      default: lvl = (a == ccm_pkg::ADV_DEF) ? 2 : (a == ccm_pkg::ADV_MID) ? 4 :
                     (a == ccm_pkg::ADV_HIGH || !s) ? 6 : 8;
    endcase
    return 8'((9'h001 << lvl) - 9'h001);
  endfunction

  assign cmp_cc1 = crossed(term1, snk, adv);
  assign cmp_cc2 = crossed(term2, snk, adv);
endmodule // cc_partner_model
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic          clk, srst, wr, rd, snk;
  logic [4:0]    addr;
  logic [7:0]    wdata, rdata, cmp_cc1, cmp_cc2;
  logic [63:0]   thr_level;
  logic [1:0]    sample_en, mon_attach, mon_detach, term1, term2;
  logic          vbus_en, vconn_en, match_valid_flag, dbg_acc, aud_acc;
  ccm_pkg::adv_t adv;
  int            errors, comparisons, cycles;

  cc_threshold_match_classifier u_cc_threshold_match_classifier (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_cc1(cmp_cc1), .cmp_cc2(cmp_cc2), .thr_level(thr_level), .sample_en(sample_en),
    .vbus_en(vbus_en), .vconn_en(vconn_en), .match_valid_flag(match_valid_flag),
    .dbg_acc(dbg_acc), .aud_acc(aud_acc), .mon_attach(mon_attach), .mon_detach(mon_detach));

  cc_partner_model u_cc_partner_model (
    .snk(snk), .adv(adv), .term1(term1), .term2(term2), .cmp_cc1(cmp_cc1), .cmp_cc2(cmp_cc2));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run;
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, e);
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask

  // Programs one role and termination pair, then checks the debounced result.
  task automatic run_case(input logic s, input ccm_pkg::adv_t a, input logic [7:0] mk, input logic [1:0] t1,
                          input logic [1:0] t2, input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] eo);
    int n;
    do_reset;
    snk   <= s;
    adv   <= a;
    term1 <= t1;
    term2 <= t2;
    #1;
    check({vbus_en, vconn_en, dbg_acc, aud_acc, mon_attach, mon_detach}, 8'h00);
    bus_wr(ccm_pkg::A_DBCLR1, mk);
    bus_wr(ccm_pkg::A_DBCLR2, mk);
    bus_wr(ccm_pkg::A_MEN1, mk);
    bus_wr(ccm_pkg::A_MEN2, mk);
    bus_wr(ccm_pkg::A_CTRL, {4'h3, a, s, 1'b1});
    n = 0;
    while (match_valid_flag !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(match_valid_flag, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    check(sample_en, 2'b11);
    check({vbus_en, vconn_en, dbg_acc, aud_acc, mon_attach, mon_detach} & (s ? 8'hcf : 8'hff), eo);
    rd_chk(ccm_pkg::A_MATCH1, e1);
    rd_chk(ccm_pkg::A_MATCH2, e2);
    rd_chk(ccm_pkg::A_CHG1, e1);
    rd_chk(ccm_pkg::A_CHG2, e2);
  endtask

  initial
  begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 8'h00;
    snk = 1'b0; adv = ccm_pkg::ADV_DEF; term1 = 2'h0; term2 = 2'h0;
    errors = 0; comparisons = 0; cycles = 0;
    do_reset;
    #1;
    check(thr_level, ccm_pkg::RST_THR);
    rd_chk(ccm_pkg::A_CTRL, ccm_pkg::RST_CTRL);
    rd_chk(ccm_pkg::A_DEB, ccm_pkg::RST_DEB);
    rd_chk(ccm_pkg::A_MEN1, ccm_pkg::RST_MASK);
    rd_chk(5'h1f, 8'h00);
    bus_wr(ccm_pkg::A_MATCH1, 8'hff);
    rd_chk(ccm_pkg::A_MATCH1, 8'h00);
    bus_wr(ccm_pkg::A_THR0 + 5'h03, 8'h5a);
    #1;
    check(thr_level[31:24], 8'h5a);
    rd_chk(ccm_pkg::A_THR0 + 5'h03, 8'h5a);
    run_case(1'b0, ccm_pkg::ADV_DEF,  8'h21, 2'h0, 2'h0, 8'h21, 8'h21, 8'h0c);
    run_case(1'b0, ccm_pkg::ADV_MID,  8'h22, 2'h1, 2'h0, 8'h02, 8'h22, 8'h81);
    run_case(1'b0, ccm_pkg::ADV_HIGH, 8'h48, 2'h2, 2'h0, 8'h00, 8'h48, 8'h09);
    run_case(1'b0, ccm_pkg::ADV_HIGH, 8'h48, 2'h2, 2'h1, 8'h00, 8'h08, 8'hc2);
    rd_chk(ccm_pkg::A_STAT, 8'h19);
    rd_chk(ccm_pkg::A_MON, 8'h08);
    run_case(1'b0, ccm_pkg::ADV_DEF,  8'h21, 2'h1, 2'h1, 8'h01, 8'h01, 8'h23);
    run_case(1'b0, ccm_pkg::ADV_MID,  8'h22, 2'h2, 2'h2, 8'h00, 8'h00, 8'h13);
    run_case(1'b0, ccm_pkg::ADV_VND,  8'h80, 2'h0, 2'h0, 8'h80, 8'h80, 8'h0c);
    run_case(1'b1, ccm_pkg::ADV_DEF,  8'h15, 2'h3, 2'h0, 8'h01, 8'h00, 8'h01);
    run_case(1'b1, ccm_pkg::ADV_DEF,  8'h15, 2'h2, 2'h0, 8'h00, 8'h00, 8'h00);
    run_case(1'b1, ccm_pkg::ADV_MID,  8'h15, 2'h0, 2'h3, 8'h00, 8'h05, 8'h02);
    run_case(1'b1, ccm_pkg::ADV_VND,  8'h95, 2'h3, 2'h0, 8'h95, 8'h00, 8'h01);
    run_case(1'b1, ccm_pkg::ADV_HIGH, 8'h15, 2'h3, 2'h0, 8'h15, 8'h00, 8'h01);
    rd_chk(ccm_pkg::A_STAT, 8'hc1);
    rd_chk(ccm_pkg::A_MON, 8'h04);
    bus_wr(ccm_pkg::A_CHG1, 8'hff);
    rd_chk(ccm_pkg::A_CHG1, 8'h00);
    bus_wr(ccm_pkg::A_DEB, 8'h03);
    adv <= ccm_pkg::ADV_MID;
    repeat (150) @(posedge clk);
    rd_chk(ccm_pkg::A_MATCH1, 8'h15);
    repeat (300) @(posedge clk);
    rd_chk(ccm_pkg::A_MATCH1, 8'h05);
    rd_chk(ccm_pkg::A_STAT, 8'ha1);
    rd_chk(ccm_pkg::A_CHG1, 8'h10);
    rd_chk(ccm_pkg::A_CHG1, 8'h10);
    bus_wr(ccm_pkg::A_CHG1, 8'h10);
    rd_chk(ccm_pkg::A_CHG1, 8'h00);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
